// File: verilog/evlog_recorder.sv
// event log recorder: fatal flash log and circular soft log
`timescale 1ns/1ps
`include "evlog_consts.svh"
module evlog_recorder
  import evlog_pkg::*;
#(
  parameter int FATAL_ENTRIES = `EVLOG_FATAL_ENTRIES,
  parameter int SOFT_ENTRIES = `EVLOG_SOFT_ENTRIES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  // time base
  input wire evlog_time_type time_i,
  input wire logic time_valid_i,
  // fatal error report
  input wire logic fatal_i,
  input wire logic [15:0] fatal_code_i,
  input wire logic [15:0] fatal_status_i,
  input wire logic [175:0] fatal_info_i,
  // soft event report
  input wire logic soft_i,
  input wire logic [6:0] soft_ident_i,
  input wire logic [7:0] soft_cond_i,
  // host commands
  input wire logic [127:0] notify_mask_i,
  input wire logic mask_we_i,
  input wire logic soft_erase_i,
  input wire logic cold_start_test_i,
  input wire logic soft_rd_i,
  input wire logic [6:0] soft_rd_idx_i,
  input wire logic fatal_rd_i,
  input wire logic [4:0] fatal_rd_idx_i,
  input wire logic notify_ack_i,
  // log reads
  output evlog_soft_type soft_rd_data_o,
  output logic [7:0] soft_count_o,
  output logic [6:0] soft_wr_ptr_o,
  output evlog_fatal_type fatal_rd_data_o,
  output logic [5:0] fatal_count_o,
  // notifications and actions
  output logic soft_notify_o,
  output evlog_soft_type soft_notify_data_o,
  output logic fatal_notify_o,
  output logic [15:0] fatal_notify_code_o,
  output logic clear_ram_o,
  output logic restart_o,
  output logic monitor_mode_o,
  output logic busy_o
);
  // refuse log sizes the pointers and counts cannot hold
  if (SOFT_ENTRIES < 2 || SOFT_ENTRIES > 127
      || FATAL_ENTRIES < 1 || FATAL_ENTRIES > 31) begin : gen_size_check
    $error("evlog_recorder: unsupported log size");
  end

  typedef enum {ST_IDLE, ST_ERASE, ST_WRITE, ST_NOTIFY, ST_CLEAR, ST_RESTART, ST_MONITOR}
    evlog_state_type;

  // upper byte of a hardware fault code
  function automatic logic is_hw_code(input logic [15:0] code);
    return code[15:8] == `EVLOG_SRC_HW0 || code[15:8] == `EVLOG_SRC_HW1;
  endfunction

  // next slot of a ring with the given number of entries
  function automatic int ring_next(input int ptr, input int entries);
    return (ptr == entries - 1) ? 0 : ptr + 1;
  endfunction

  // fatal code classification
  function automatic evlog_action_type classify(input logic [15:0] code);
    evlog_action_type act;
    act = EVLOG_ACT_NONE;
    if (code[15:8] == `EVLOG_SRC_IRQ)
      act = EVLOG_ACT_HARD;
    else if (code == `EVLOG_CODE_RAM_FAIL || code == `EVLOG_CODE_ROM_FAIL)
      act = EVLOG_ACT_MONITOR;
    else if (is_hw_code(code))
      act = EVLOG_ACT_RESET;
    else if (code >= `EVLOG_CODE_OS_FIRST && code <= `EVLOG_CODE_OS_LAST)
      act = EVLOG_ACT_RESET;
    else if (code == `EVLOG_CODE_QUEUE_FULL)
      act = EVLOG_ACT_RESET;
    else if (code == `EVLOG_CODE_SERIAL_OPEN)
      act = EVLOG_ACT_MONITOR;
    else if (code == `EVLOG_CODE_EXPORT_LIMIT || code == `EVLOG_CODE_NAV_LIB)
      act = EVLOG_ACT_HARD;
    else if (code[15:8] == `EVLOG_SRC_OS || code[15:8] == `EVLOG_SRC_NAV)
      act = EVLOG_ACT_RESET;
    return act;
  endfunction

  // info block pruned to the fields defined for the code's source
  function automatic logic [175:0] shape_info(input logic [15:0] code, input logic [175:0] raw);
    logic [175:0] blk;
    blk = '0;
    if (code[15:8] == `EVLOG_SRC_IRQ)
      blk[175:104] = {code[7:0], raw[167:104]};
    else if (is_hw_code(code))
      blk[175:80] = {raw[175:112],
        (code == `EVLOG_CODE_ROM_FAIL) ? raw[111:80] : 32'h0};
    else if (code[15:12] == 4'h2)
      blk[175:152] = raw[175:152];
    else
      blk = raw;
    return blk;
  endfunction

  // storage: flash image for fatal log, battery-backed ring for soft log
  evlog_fatal_type fatal_mem [FATAL_ENTRIES];
  evlog_soft_type soft_mem [SOFT_ENTRIES];
  logic [SOFT_ENTRIES-1:0] cond_active_ff;

  evlog_state_type state_ff;
  evlog_fatal_type pend_ff;
  evlog_action_type act_ff;
  logic [4:0] fat_ptr_ff;
  logic [6:0] soft_ptr_ff;
  logic [127:0] mask_ff;
  evlog_soft_type nxt_soft;
  logic soft_ok;
  logic soft_log;

  // soft entry built from the current time
  always_comb begin
    nxt_soft.msec = time_i.msec;
    nxt_soft.week = time_i.week;
    nxt_soft.ident = {1'b0, soft_ident_i};
    nxt_soft.cond = soft_cond_i;
    nxt_soft.rsvd = 16'h0;
    soft_ok = soft_i && soft_ident_i != 7'h0 && (soft_cond_i == `EVLOG_COND_SINGLE
      || soft_cond_i == `EVLOG_COND_NEW || soft_cond_i == `EVLOG_COND_STILL
      || soft_cond_i == `EVLOG_COND_CLEARED);
    soft_log = soft_ok && soft_cond_i != `EVLOG_COND_STILL;
  end

  // fatal sequence: erase slot, write, notify, then act
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_ff <= ST_IDLE;
      pend_ff <= '0;
      act_ff <= EVLOG_ACT_NONE;
      fat_ptr_ff <= 5'h0;
      fatal_count_o <= 6'h0;
      fatal_notify_o <= 1'b0;
      fatal_notify_code_o <= 16'h0;
      clear_ram_o <= 1'b0;
      restart_o <= 1'b0;
      monitor_mode_o <= 1'b0;
      busy_o <= 1'b0;
    end else if (clk_en_i) begin
      restart_o <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (fatal_i) begin
            pend_ff.msec <= time_valid_i ? time_i.msec : `EVLOG_MSEC_UNKNOWN;
            pend_ff.week <= time_valid_i ? time_i.week : `EVLOG_WEEK_UNKNOWN;
            pend_ff.code <= fatal_code_i;
            pend_ff.status <= fatal_status_i;
            pend_ff.info <= shape_info(fatal_code_i, fatal_info_i);
            act_ff <= classify(fatal_code_i);
            busy_o <= 1'b1;
            state_ff <= ST_ERASE;
          end
        end
        ST_ERASE: state_ff <= ST_WRITE;
        ST_WRITE: begin
          fat_ptr_ff <= 5'(ring_next(32'(fat_ptr_ff), FATAL_ENTRIES));
          if (32'(fatal_count_o) < FATAL_ENTRIES)
            fatal_count_o <= fatal_count_o + 6'h1;
          fatal_notify_o <= 1'b1;
          fatal_notify_code_o <= pend_ff.code;
          state_ff <= ST_NOTIFY;
        end
        ST_NOTIFY: begin
          if (notify_ack_i) begin
            fatal_notify_o <= 1'b0;
            case (act_ff)
              EVLOG_ACT_HARD: begin
                clear_ram_o <= 1'b1;
                state_ff <= ST_CLEAR;
              end
              EVLOG_ACT_MONITOR: begin
                monitor_mode_o <= 1'b1;
                state_ff <= ST_MONITOR;
              end
              default: state_ff <= ST_RESTART;
            endcase
          end
        end
        ST_CLEAR: begin
          clear_ram_o <= 1'b0;
          state_ff <= ST_RESTART;
        end
        ST_RESTART: begin
          restart_o <= 1'b1;
          busy_o <= 1'b0;
          state_ff <= ST_IDLE;
        end
        ST_MONITOR: state_ff <= ST_MONITOR;
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // flash write after the erase step; no host path erases it
  always_ff @(posedge clk_i) begin
    if (clk_en_i && state_ff == ST_ERASE)
      fatal_mem[fat_ptr_ff] <= '1;
    else if (clk_en_i && state_ff == ST_WRITE)
      fatal_mem[fat_ptr_ff] <= pend_ff;
  end

  // soft ring write
  always_ff @(posedge clk_i) begin
    if (clk_en_i && soft_log && !soft_erase_i && !cold_start_test_i)
      soft_mem[soft_ptr_ff] <= nxt_soft;
  end

  // soft ring pointer and fill level
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      soft_ptr_ff <= 7'h0;
      soft_count_o <= 8'h0;
    end else if (clk_en_i) begin
      if (soft_erase_i || cold_start_test_i) begin
        soft_ptr_ff <= 7'h0;
        soft_count_o <= 8'h0;
      end else if (soft_log) begin
        soft_ptr_ff <= 7'(ring_next(32'(soft_ptr_ff), SOFT_ENTRIES));
        if (32'(soft_count_o) < SOFT_ENTRIES)
          soft_count_o <= soft_count_o + 8'h1;
      end
    end
  end

  // persistent condition tracking, indexed by identity
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cond_active_ff <= '0;
    end else if (clk_en_i && soft_ok && 32'(soft_ident_i) < SOFT_ENTRIES) begin
      if (soft_cond_i == `EVLOG_COND_NEW || soft_cond_i == `EVLOG_COND_STILL)
        cond_active_ff[soft_ident_i] <= 1'b1;
      else if (soft_cond_i == `EVLOG_COND_CLEARED)
        cond_active_ff[soft_ident_i] <= 1'b0;
    end
  end

  // host notification mask and soft notification
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mask_ff <= '0;
      soft_notify_o <= 1'b0;
      soft_notify_data_o <= '0;
    end else if (clk_en_i) begin
      if (mask_we_i)
        mask_ff <= notify_mask_i;
      soft_notify_o <= soft_ok && mask_ff[soft_ident_i];
      if (soft_ok)
        soft_notify_data_o <= nxt_soft;
    end
  end

  // host log reads
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      soft_rd_data_o <= '0;
      fatal_rd_data_o <= '0;
      soft_wr_ptr_o <= 7'h0;
    end else if (clk_en_i) begin
      soft_wr_ptr_o <= soft_ptr_ff;
      if (soft_rd_i && 32'(soft_rd_idx_i) < SOFT_ENTRIES)
        soft_rd_data_o <= soft_mem[soft_rd_idx_i];
      if (fatal_rd_i && 32'(fatal_rd_idx_i) < FATAL_ENTRIES)
        fatal_rd_data_o <= fatal_mem[fatal_rd_idx_i];
    end
  end
endmodule

// File: common/evlog_consts.svh
// constants of the event log recorder: codes, sizes and fill values
`ifndef EVLOG_CONSTS_SVH
`define EVLOG_CONSTS_SVH
`define EVLOG_SRC_IRQ 8'h10
`define EVLOG_SRC_HW0 8'h12
`define EVLOG_SRC_HW1 8'h13
`define EVLOG_SRC_OS 8'h20
`define EVLOG_SRC_OS2 8'h21
`define EVLOG_SRC_NAV 8'h40
`define EVLOG_CODE_RAM_FAIL 16'h1200
`define EVLOG_CODE_ROM_FAIL 16'h1201
`define EVLOG_CODE_OS_FIRST 16'h2001
`define EVLOG_CODE_OS_LAST 16'h200C
`define EVLOG_CODE_QUEUE_FULL 16'h2120
`define EVLOG_CODE_SERIAL_OPEN 16'h2121
`define EVLOG_CODE_EXPORT_LIMIT 16'h4001
`define EVLOG_CODE_NAV_LIB 16'h4003
`define EVLOG_MSEC_UNKNOWN 32'hFFFFFFFF
`define EVLOG_WEEK_UNKNOWN 16'hFFFF
`define EVLOG_COND_SINGLE 8'h00
`define EVLOG_COND_NEW 8'h10
`define EVLOG_COND_STILL 8'h20
`define EVLOG_COND_CLEARED 8'h30
`define EVLOG_FATAL_ENTRIES 31
`define EVLOG_SOFT_ENTRIES 127
`endif

// File: common/evlog_pkg.sv
// types of the event log recorder
package evlog_pkg;
  // fatal entry, 32 bytes: msec, week, code, status, 22-byte info
  typedef struct packed {
    logic [31:0] msec;
    logic [15:0] week;
    logic [15:0] code;
    logic [15:0] status;
    logic [175:0] info;
  } evlog_fatal_type;
  // soft entry, 10 bytes: msec, week, identity, condition, reserved
  typedef struct packed {
    logic [31:0] msec;
    logic [15:0] week;
    logic [7:0] ident;
    logic [7:0] cond;
    logic [15:0] rsvd;
  } evlog_soft_type;
  typedef struct packed {
    logic [31:0] msec;
    logic [15:0] week;
  } evlog_time_type;
  typedef enum logic [1:0] {
    EVLOG_ACT_NONE,
    EVLOG_ACT_RESET,
    EVLOG_ACT_HARD,
    EVLOG_ACT_MONITOR
  } evlog_action_type;
endpackage

// File: verif/evlog_host_model.sv
// host model that acknowledges fatal notifications after a chosen delay
`timescale 1ns/1ps
module evlog_host_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // notification handshake
  input wire logic fatal_notify_i,
  input wire logic [3:0] delay_i,
  output logic notify_ack_o
);
  logic [3:0] wait_ff;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wait_ff <= 4'h0;
      notify_ack_o <= 1'b0;
    end else if (fatal_notify_i && !notify_ack_o) begin
      wait_ff <= wait_ff + 4'h1;
      notify_ack_o <= (wait_ff >= delay_i);
    end else begin
      wait_ff <= 4'h0;
      notify_ack_o <= 1'b0;
    end
  end
endmodule

// File: verif/evlog_recorder_properties.sv
// port assertions of the event log recorder
`timescale 1ns/1ps
module evlog_recorder_properties
  import evlog_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  // requests
  input wire logic fatal_i,
  input wire logic soft_i,
  input wire logic [6:0] soft_ident_i,
  input wire logic [7:0] soft_cond_i,
  input wire logic [127:0] notify_mask_i,
  input wire logic mask_we_i,
  input wire logic notify_ack_i,
  // results
  input wire logic [7:0] soft_count_o,
  input wire logic [5:0] fatal_count_o,
  input wire logic soft_notify_o,
  input wire evlog_soft_type soft_notify_data_o,
  input wire logic fatal_notify_o,
  input wire logic clear_ram_o,
  input wire logic restart_o,
  input wire logic monitor_mode_o,
  input wire logic busy_o
);
  logic [127:0] mask_ff;
  logic mask_ok_ff;
  logic take;
  logic soft_ok;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mask_ok_ff <= 1'b0;
    end else if (clk_en_i && mask_we_i) begin
      mask_ok_ff <= 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (clk_en_i && mask_we_i) begin
      mask_ff <= notify_mask_i;
    end
  end
  assign take = clk_en_i && fatal_i && !busy_o && !monitor_mode_o;
  assign soft_ok = clk_en_i && soft_i && mask_ok_ff && soft_ident_i != 7'h00
    && soft_cond_i[3:0] == 4'h0 && soft_cond_i[7:6] == 2'h0;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence notify_seq;
    busy_o ##2 fatal_notify_o;
  endsequence
  sequence hard_seq;
    clear_ram_o ##1 !clear_ram_o ##1 restart_o;
  endsequence
  fatal_notify_a: assert property (take |=> notify_seq)
    else $error("fatal notification late");
  notify_hold_a: assert property (
    fatal_notify_o && !notify_ack_i && clk_en_i |=> fatal_notify_o)
    else $error("fatal notification dropped early");
  hard_order_a: assert property ($rose(clear_ram_o) |-> hard_seq)
    else $error("restart not after memory clear");
  restart_pulse_a: assert property (restart_o |=> !restart_o)
    else $error("restart longer than one cycle");
  monitor_stay_a: assert property (monitor_mode_o |=> monitor_mode_o && !restart_o)
    else $error("monitor mode left or restarted");
  soft_notify_a: assert property (
    soft_ok && mask_ff[soft_ident_i] |=> soft_notify_o
    && soft_notify_data_o.ident == {1'b0, $past(soft_ident_i)}
    && soft_notify_data_o.cond == $past(soft_cond_i))
    else $error("enabled soft event not notified");
  soft_quiet_a: assert property (soft_ok && !mask_ff[soft_ident_i] |=> !soft_notify_o)
    else $error("masked soft event notified");
  count_limit_a: assert property (soft_count_o <= 8'h7F && fatal_count_o <= 6'h1F)
    else $error("log count above capacity");
endmodule
bind evlog_recorder evlog_recorder_properties chk (.clk_i, .reset_n_i, .clk_en_i, .fatal_i,
  .soft_i, .soft_ident_i, .soft_cond_i, .notify_mask_i, .mask_we_i, .notify_ack_i,
  .soft_count_o, .fatal_count_o, .soft_notify_o, .soft_notify_data_o, .fatal_notify_o,
  .clear_ram_o, .restart_o, .monitor_mode_o, .busy_o);

// File: verif/evlog_recorder_test.sv
// self-checking bench of the event log recorder
`timescale 1ns/1ps
module evlog_recorder_test import evlog_pkg::*;;
  logic clk_i, reset_n_i, clk_en_i, time_valid_i, fatal_i, soft_i, mask_we_i;
  logic soft_erase_i, cold_start_test_i, soft_rd_i, fatal_rd_i, notify_ack_i;
  logic soft_notify_o, fatal_notify_o, clear_ram_o, restart_o, monitor_mode_o, busy_o;
  evlog_time_type time_i;
  logic [15:0] fatal_code_i, fatal_status_i, fatal_notify_code_o;
  logic [175:0] fatal_info_i;
  logic [6:0] soft_ident_i, soft_rd_idx_i, soft_wr_ptr_o;
  logic [7:0] soft_cond_i, soft_count_o;
  logic [127:0] notify_mask_i;
  logic [4:0] fatal_rd_idx_i;
  logic [5:0] fatal_count_o;
  logic [3:0] ack_delay;
  evlog_soft_type soft_rd_data_o, soft_notify_data_o;
  evlog_fatal_type fatal_rd_data_o;
  int err_count, total_checks, n_clear, n_restart, n_snote;
  evlog_recorder uut (.clk_i, .reset_n_i, .clk_en_i, .time_i, .time_valid_i, .fatal_i,
    .fatal_code_i, .fatal_status_i, .fatal_info_i, .soft_i, .soft_ident_i, .soft_cond_i,
    .notify_mask_i, .mask_we_i, .soft_erase_i, .cold_start_test_i, .soft_rd_i, .soft_rd_idx_i,
    .fatal_rd_i, .fatal_rd_idx_i, .notify_ack_i, .soft_rd_data_o, .soft_count_o, .soft_wr_ptr_o,
    .fatal_rd_data_o, .fatal_count_o, .soft_notify_o, .soft_notify_data_o, .fatal_notify_o,
    .fatal_notify_code_o, .clear_ram_o, .restart_o, .monitor_mode_o, .busy_o);
  evlog_host_model host (.clk_i, .reset_n_i, .fatal_notify_i(fatal_notify_o),
    .delay_i(ack_delay), .notify_ack_o(notify_ack_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (clear_ram_o === 1'b1) n_clear++;
    if (restart_o === 1'b1) n_restart++;
    if (soft_notify_o === 1'b1) n_snote++;
  end
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic soft_ev(input logic [6:0] id, input logic [7:0] c, input logic clr);
    soft_i <= 1'b1;
    soft_ident_i <= id;
    soft_cond_i <= c;
    cold_start_test_i <= clr;
    tick(1);
    soft_i <= 1'b0;
    cold_start_test_i <= 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [6:0] idx, input logic fat);
    soft_rd_i <= !fat;
    fatal_rd_i <= fat;
    soft_rd_idx_i <= idx;
    fatal_rd_idx_i <= idx[4:0];
    tick(1);
    soft_rd_i <= 1'b0;
    fatal_rd_i <= 1'b0;
    tick(2);
  endtask
  task automatic t_soft_cond;
    soft_erase_i <= 1'b1;
    notify_mask_i <= 128'h20;
    mask_we_i <= 1'b1;
    time_i <= {32'h0000_1234, 16'h0456};
    tick(1);
    soft_erase_i <= 1'b0;
    mask_we_i <= 1'b0;
    tick(1);
    n_snote = 0;
    soft_ev(7'h05, 8'h10, 1'b0);
    soft_ev(7'h05, 8'h20, 1'b0);
    soft_ev(7'h05, 8'h30, 1'b0);
    soft_ev(7'h06, 8'h00, 1'b0);
    tick(2);
    chk(n_snote, 3);
    chk(soft_count_o, 3);
    rd(7'h01, 1'b0);
    chk({soft_rd_data_o.ident, soft_rd_data_o.cond}, 16'h0530);
    chk({soft_rd_data_o.msec, soft_rd_data_o.week}, {32'h0000_1234, 16'h0456});
  endtask
  task automatic t_ring;
    for (int i = 0; i < 130; i++) begin
      time_i <= {32'(i), 16'h0800};
      soft_ev(7'((i % 127) + 1), 8'h00, 1'b0);
    end
    tick(2);
    chk(soft_count_o, 127);
    chk(soft_wr_ptr_o, 6);
    rd(7'h00, 1'b0);
    chk(soft_rd_data_o.msec, 124);
    soft_ev(7'h02, 8'h00, 1'b1);
    tick(2);
    chk(soft_count_o, 0);
  endtask
  task automatic t_fatal;
    logic [15:0] codes [6] = '{16'h1005, 16'h2120, 16'h4001, 16'h4003, 16'h200C, 16'h1201};
    logic [1:0] kind [6] = '{2'h1, 2'h0, 2'h1, 2'h1, 2'h0, 2'h2};
    for (int k = 0; k < 6; k++) begin
      n_clear = 0;
      n_restart = 0;
      ack_delay <= 4'(k * 2);
      time_valid_i <= k[0];
      time_i <= {32'h0001_0000 + 32'(k), 16'h0900};
      fatal_code_i <= codes[k];
      fatal_status_i <= 16'(k);
      fatal_i <= 1'b1;
      tick(1);
      fatal_i <= 1'b0;
      for (int i = 0; i < 30 && fatal_notify_o !== 1'b1; i++) tick(1);
      chk(fatal_notify_code_o, codes[k]);
      for (int i = 0; i < 40 && busy_o !== 1'b0; i++) tick(1);
      tick(3);
      chk(n_clear, kind[k] == 2'h1);
      chk(n_restart, kind[k] != 2'h2);
      chk(monitor_mode_o, kind[k] == 2'h2);
      chk(fatal_count_o, k + 1);
      rd(7'(k), 1'b1);
      chk({fatal_rd_data_o.code, fatal_rd_data_o.status}, {codes[k], 16'(k)});
      chk(fatal_rd_data_o.msec, k[0] ? 32'h0001_0000 + 32'(k) : 32'hFFFF_FFFF);
      if (k == 0) chk(fatal_rd_data_o.info[175:168], 8'h05);
    end
    fatal_i <= 1'b1;
    tick(1);
    fatal_i <= 1'b0;
    tick(6);
    chk(fatal_count_o, 6);
  endtask
  task automatic t_reset_codes;
    logic [15:0] codes [4] = '{16'h1305, 16'h4002, 16'h2003, 16'h2121};
    reset_n_i <= 1'b0;
    ack_delay <= 4'h1;
    time_valid_i <= 1'b1;
    time_i <= {32'h0002_0000, 16'h0A00};
    tick(2);
    chk({monitor_mode_o, busy_o, fatal_count_o}, 8'h00);
    reset_n_i <= 1'b1;
    clk_en_i <= 1'b0;
    soft_ev(7'h07, 8'h00, 1'b0);
    chk(soft_count_o, 0);
    clk_en_i <= 1'b1;
    soft_ev(7'h07, 8'h00, 1'b0);
    chk(soft_count_o, 1);
    soft_ev(7'h00, 8'h00, 1'b0);
    chk(soft_count_o, 1);
    soft_ev(7'h08, 8'h40, 1'b0);
    chk(soft_count_o, 1);
    for (int k = 0; k < 4; k++) begin
      n_clear = 0;
      n_restart = 0;
      fatal_code_i <= codes[k];
      fatal_status_i <= 16'h0;
      fatal_i <= 1'b1;
      tick(1);
      fatal_i <= 1'b0;
      tick(1);
      for (int i = 0; i < 40 && busy_o !== 1'b0; i++) tick(1);
      tick(3);
      chk(n_clear, 0);
      chk(n_restart, k != 3);
      chk(monitor_mode_o, k == 3);
      chk(fatal_count_o, k + 1);
      rd(7'(k), 1'b1);
      chk({fatal_rd_data_o.code, fatal_rd_data_o.week}, {codes[k], 16'h0A00});
      if (k == 0) chk(fatal_rd_data_o.info[127:80], 48'hA5C3_0000_0000);
      if (k == 2) chk(fatal_rd_data_o.info[175:128], 48'hA5C3_A500_0000);
    end
  endtask
  task automatic complete_run;
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    {reset_n_i, time_valid_i, fatal_i, soft_i, mask_we_i, soft_erase_i} = '0;
    {cold_start_test_i, soft_rd_i, fatal_rd_i, soft_rd_idx_i, fatal_rd_idx_i} = '0;
    {fatal_code_i, fatal_status_i, soft_ident_i, soft_cond_i, notify_mask_i} = '0;
    clk_en_i = 1'b1;
    ack_delay = 4'h0;
    time_i = '0;
    fatal_info_i = {11{16'hA5C3}};
    tick(5);
    reset_n_i <= 1'b1;
    tick(1);
    t_soft_cond();
    t_ring();
    t_fatal();
    t_reset_codes();
    complete_run();
  end
  initial begin
    tick(20000);
    err_count++;
    complete_run();
  end
endmodule
